// ==== bench/ram_user.sv ====
// Behavioural user logic driving one port of the RAM block
module ram_user (
  // Clock
  input  logic        clk,
  // Port request
  output logic [11:0] addr,
  output logic [35:0] din,
  output logic        wren,
  output logic        rden,
  output logic [3:0]  byteen
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {addr, din, wren, rden, byteen} = '0;
  end

  ////////////////////////////////////////
  // A read is never asked for together with a write
  // Idle cycles invert din so stale data cannot pass for a result
  task automatic op(input logic w, input logic r, input logic [11:0] a,
                    input logic [35:0] d, input logic [3:0] be);
    @(posedge clk);
    wren   <= w;
    rden   <= r && !w;
    addr   <= a;
    din    <= w ? d : ~din;
    byteen <= be;
  endtask
endmodule

// ==== bench/sync_ram_block_sva.sv ====
// Port-level assertions for the synchronous RAM block
module sync_ram_block_sva (
  // Clock, reset, enable, clears
  input logic        clk,
  input logic        rst_n,
  input logic        ce,
  input logic        clr_in,
  input logic        clr_out,
  // RAM ports
  input logic [35:0] a_din,
  input logic        a_wren,
  input logic        a_rden,
  input logic [3:0]  a_byteen,
  input logic [35:0] a_dout,
  input logic [35:0] b_dout,
  // Wishbone
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [3:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o
);
  logic [6:0]  ctrl_r;
  logic        req;
  logic        wr36;
  logic        go;
  logic        idle;
  logic [35:0] m;
  logic [35:0] dm;

  // The mode is not on the ports, so CTRL is shadowed from bus writes
  assign req  = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr36 = ce && a_wren && !clr_in && !clr_out && ctrl_r[3:0] == 4'h8;
  assign go   = ce && !clr_out;
  assign idle = ce && !a_wren && !a_rden && !clr_in && !clr_out && !req;
  assign m    = {{9{a_byteen[3]}}, {9{a_byteen[2]}}, {9{a_byteen[1]}},
                 {9{a_byteen[0]}}};
  assign dm   = a_din & m;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 7'h48;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0) begin
      ctrl_r <= wb_dat_i[6:0];
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_zero: assert property ($rose(rst_n) |->
    a_dout == 36'h0 && b_dout == 36'h0) else $error("dout not zero");
  a_new_data: assert property (wr36 && !ctrl_r[4] ##1 go |=>
    (a_dout & $past(m, 2)) == $past(dm, 2)) else $error("bypass data");
  a_reg_late: assert property (wr36 && ctrl_r[4] ##1 go ##1 go |=>
    (a_dout & $past(m, 3)) == $past(dm, 3)) else $error("outreg data");
  a_hold_idle: assert property (idle [*3] |=> $stable(a_dout))
    else $error("dout moved while idle");
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");

  c_masked: cover property (wr36 && a_byteen != 4'hf);
  c_outreg: cover property (a_rden && ctrl_r[4]);
  c_split: cover property (wr36 && ctrl_r[5]);
endmodule

// ==== bench/sync_ram_block_tb.sv ====
// Self-checking testbench for the synchronous RAM block
`include "ram_block_regs.vh"

module sync_ram_block_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic        ce          = 1'b1;
  logic        clr_in      = 1'b0;
  logic        clr_out     = 1'b0;
  logic [11:0] a_addr, b_addr;
  logic [35:0] a_din, b_din, a_dout, b_dout, e;
  logic        a_wren, b_wren, a_rden, b_rden, msk;
  logic [3:0]  a_byteen, b_byteen, wb_adr_i, wb_sel_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [35:0] mem [0:127];
  int          err_total   = 0;
  int          comparisons = 0;
  int          w, lw, lat;
  logic [3:0]  md [7] = '{`MODE_X36, `MODE_X18, `MODE_X32, `MODE_X9,
                          `MODE_X16, `MODE_X8, `MODE_X36};
  int          wt [7] = '{36, 18, 32, 9, 16, 8, 36};

  always #10 clk = ~clk;

  sync_ram_block u_sync_ram_block (.clk, .rst_n, .ce, .clr_in, .clr_out,
    .a_addr, .a_din, .a_wren, .a_rden, .a_byteen, .a_dout,
    .b_addr, .b_din, .b_wren, .b_rden, .b_byteen, .b_dout,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  ram_user u_ram_user (.clk, .addr(a_addr), .din(a_din), .wren(a_wren),
    .rden(a_rden), .byteen(a_byteen));
  ram_user u_ram_user_b (.clk, .addr(b_addr), .din(b_din), .wren(b_wren),
    .rden(b_rden), .byteen(b_byteen));

  ////////////////////////////////////////
  task automatic chk(string nm, logic [35:0] x, logic [35:0] y);
    comparisons++;
    if (y !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [35:0] rnd;
    return 36'({$urandom(), $urandom()});
  endfunction

  // Lanes are lw bits wide; bits above the mode width read as zero
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] d,
                                        logic [3:0] be);
    logic [35:0] r;
    for (int b = 0; b < 36; b++)
      r[b] = b >= w ? 1'b0 : (be[b / lw] || !msk) ? d[b] : o[b];
    return r;
  endfunction

  task automatic wb(logic we, logic [3:0] adr, logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, d};
    // Data is taken and the request dropped at the edge that sees ack high
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_dat_i} <= {2'b00, ~d};
  endtask

  task automatic idle;
    fork
      u_ram_user.op(0, 0, '0, '0, '0);
      u_ram_user_b.op(0, 0, '0, '0, '0);
    join
  endtask

  // With the output register on, the old word must still show one edge early
  task automatic settle(logic [35:0] p);
    @(posedge clk);
    if (lat) begin
      #1;
      chk("a_dout early", p, a_dout);
      @(posedge clk);
    end
    #1;
  endtask

  task automatic wr(int i, logic [35:0] d, logic [3:0] be);
    logic [35:0] p;
    p = a_dout;
    e = merge(mem[i], d, be);
    u_ram_user.op(1, 0, 12'(i), d, be);
    idle();
    settle(p);
    chk("a_dout write", e, a_dout);
    mem[i] = e;
  endtask

  task automatic rd(int i);
    logic [35:0] p;
    p = a_dout;
    u_ram_user.op(0, 1, 12'(i), '0, '0);
    idle();
    settle(p);
    chk("a_dout read", mem[i], a_dout);
    @(posedge clk);
    #1;
    chk("a_dout held", mem[i], a_dout);
  endtask

  task automatic reset_chk;
    #1;
    chk("a_dout reset", '0, a_dout);
    chk("b_dout reset", '0, b_dout);
    @(posedge clk);
    rst_n <= 1'b1;
    wb(0, `REG_CTRL, '0);
    chk("ctrl reset", 36'(`CTRL_RESET), 36'(q));
  endtask

  initial begin
    void'($urandom(87));
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    repeat (15) @(posedge clk);
    reset_chk();
    wb(1, 4'h8, 32'h0000_00ff);
    wb(0, 4'h8, '0);
    chk("unmapped", '0, 36'(q));
    for (int j = 0; j < 7; j++) begin
      w = wt[j];
      lw = w % 9 ? 8 : 9;
      lat = j == 6;
      msk = w >= 16;
      wb(1, `REG_CTRL, {25'h0, 2'b10, 1'(lat), md[j]});
      wb(0, `REG_STATUS, '0);
      chk("mask active", 36'(msk), 36'(q[0]));
      for (int i = 0; i < 16; i++) wr(i, rnd(), 4'hf);
      wr(2, rnd(), 4'h0);
      for (int i = 0; i < 24; i++)
        wr($urandom_range(15), rnd(), 4'($urandom()));
      for (int i = 0; i < 16; i++) rd(i);
    end
    lat = 0;
    wb(1, `REG_CTRL, 32'h0000_0048);
    rd(6);
    // Clearing the input stage forces a read at address zero
    u_ram_user.op(0, 0, 12'h005, '0, '0);
    clr_in <= 1'b1;
    @(posedge clk);
    clr_in <= 1'b0;
    @(posedge clk);
    #1;
    chk("a_dout clr_in", mem[0], a_dout);
    @(posedge clk);
    clr_out <= 1'b1;
    @(posedge clk);
    clr_out <= 1'b0;
    @(posedge clk);
    #1;
    chk("a_dout clr_out", '0, a_dout);
    // A write offered while ce is low must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    u_ram_user.op(1, 0, 12'h005, ~mem[5], 4'hf);
    idle();
    #1;
    chk("a_dout frozen", '0, a_dout);
    @(posedge clk);
    ce <= 1'b1;
    rd(5);
    for (int j = 0; j < 2; j++) begin
      wb(1, `REG_CTRL, j ? 32'h0000_0008 : 32'h0000_0048);
      e = j ? `RDW_UNKNOWN : mem[3];
      mem[3] = rnd();
      fork
        u_ram_user.op(1, 0, 12'h003, mem[3], 4'hf);
        u_ram_user_b.op(0, 1, 12'h003, '0, '0);
      join
      idle();
      settle('0);
      chk("b_dout collide", e, b_dout);
      wb(0, `REG_STATUS, '0);
      chk("collide flag", 36'h1, 36'(q[1]));
      wb(1, `REG_STATUS, 32'h0000_0002);
    end
    wb(1, `REG_CTRL, 32'h0000_0068);
    for (int i = 0; i < 8; i++) begin
      mem[i] = rnd();
      mem[64 + i] = rnd();
      fork
        u_ram_user.op(1, 0, 12'(i), mem[i], 4'hf);
        u_ram_user_b.op(1, 0, 12'(64 + i), mem[64 + i], 4'hf);
      join
    end
    for (int i = 0; i < 8; i++) begin
      fork
        u_ram_user.op(0, 1, 12'(i), '0, '0);
        u_ram_user_b.op(0, 1, 12'(64 + i), '0, '0);
      join
      idle();
      settle('0);
      chk("a_dout split", mem[i], a_dout);
      chk("b_dout split", mem[64 + i], b_dout);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    reset_chk();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule

bind sync_ram_block sync_ram_block_sva u_sync_ram_block_sva (.clk, .rst_n,
  .ce, .clr_in, .clr_out, .a_din, .a_wren, .a_rden, .a_byteen, .a_dout,
  .b_dout, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o);

// ==== src/ram_block_regs.vh ====
// Constants for the synchronous embedded RAM block and its register map
`ifndef RAM_BLOCK_REGS_VH
`define RAM_BLOCK_REGS_VH

// Geometry: 128 words of four 9-bit lanes, 4,608 bits in all
`define RB_WORDS        128
`define RB_HALF_WORDS   64
`define RB_WORD_W       36
`define RB_LANES        4
`define RB_LANE_W       9
`define RB_BYTE_W       8
`define RB_PAR_POS      8
`define RB_ADDR_W       12
`define RB_DATA_BITS    32

// Width modes, field CTRL[3:0]
`define MODE_X1         4'h0
`define MODE_X2         4'h1
`define MODE_X4         4'h2
`define MODE_X8         4'h3
`define MODE_X9         4'h4
`define MODE_X16        4'h5
`define MODE_X18        4'h6
`define MODE_X32        4'h7
`define MODE_X36        4'h8

// Register byte offsets on the Wishbone slave
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4

// CTRL fields
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   3
`define CTRL_OUTREG     4
`define CTRL_SPLIT      5
`define CTRL_OLD_DATA   6
`define CTRL_W          7
`define CTRL_RESET      7'h48

// STATUS fields
`define STAT_MASK_OK    0
`define STAT_COLLIDE    1

// Reset and clear values, and the unknown read-during-write data
`define BE_ALL_ON       4'hf
`define RDW_UNKNOWN     36'hf_ffff_ffff
`define ZERO36          36'h0_0000_0000

`endif

// ==== src/ram_half.v ====
// One half of the storage array: one masked write port, two read ports
module ram_half #(
  parameter ROWS   = 64,
  parameter ROW_AW = 6,
  parameter WIDTH  = 36
) (
  // Clock and enable
  input  wire              clk,
  input  wire              ce,
  // Write port
  input  wire              we,
  input  wire [ROW_AW-1:0] waddr,
  input  wire [WIDTH-1:0]  wmask,
  input  wire [WIDTH-1:0]  wdata,
  // Read ports, combinational from the array
  input  wire [ROW_AW-1:0] raddr0,
  output wire [WIDTH-1:0]  rdata0,
  input  wire [ROW_AW-1:0] raddr1,
  output wire [WIDTH-1:0]  rdata1
);

  // Contents are not reset so preloaded values survive reset
  reg [WIDTH-1:0] mem [0:ROWS-1];

  assign rdata0 = mem[raddr0];
  assign rdata1 = mem[raddr1];

  always @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
  end

endmodule

// ==== src/sync_ram_block.v ====
// Synchronous embedded RAM block: shaped widths, byte lanes, split mode
// Operation
// - 512 of the 4,608 bits are per-byte parity bits, one per byte.
// - Parity positions may hold user data, giving 9, 18 or 36 bit widths.
// - Masked-off byte lanes keep the value of their last write.
// - Writes need the write strobe; the byte mask defaults to all ones.
// - Clearing the byte mask register sets every mask bit high.
// - Byte masking applies only in 16, 18, 32 and 36 bit widths.
// - Mask bit n gates 9-bit lane n: bits 8:0, 17:9, 26:18, 35:27.
// - Any mask combination works; 16/32 bit widths gate 8-bit lanes.
// - Reset zeroes the read outputs and loads a read of address zero.
// - Input and output registers have clears; read strobe clears high.
// - All inputs are registered; output stage registered or bypassed.
// - Input registers capture writes; output registers pipeline reads.
// - Each single-port operation is a read or a write, never both.
// - Block splits into two independent half-size single-port RAMs.
// - During a write the data written appears on the read outputs.
// - Bypassed output shows new write data at the writing edge.
// - Cross-port read of a word being written gives unknown or old data.
// - With read strobe low the last read data is held.
//
// Local design decisions: the Wishbone register port and the register offsets.
`include "ram_block_regs.vh"

module sync_ram_block #(
  parameter ADDR_W = 12,
  parameter DATA_W = 36,
  parameter BE_W   = 4
) (
  // Clock, reset, enable
  input  wire              clk,
  input  wire              rst_n,
  input  wire              ce,
  // Register clears
  input  wire              clr_in,
  input  wire              clr_out,
  // Port A
  input  wire [ADDR_W-1:0] a_addr,
  input  wire [DATA_W-1:0] a_din,
  input  wire              a_wren,
  input  wire              a_rden,
  input  wire [BE_W-1:0]   a_byteen,
  output reg  [DATA_W-1:0] a_dout,
  // Port B: second half in split mode, read-only otherwise
  input  wire [ADDR_W-1:0] b_addr,
  input  wire [DATA_W-1:0] b_din,
  input  wire              b_wren,
  input  wire              b_rden,
  input  wire [BE_W-1:0]   b_byteen,
  output reg  [DATA_W-1:0] b_dout,
  // Wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [3:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////
  // Mode decoding, shared by both ports

  function [2:0] shift_of;
    input [3:0] mode;
    begin
      case (mode)
        `MODE_X1:  shift_of = 3'd0;
        `MODE_X2:  shift_of = 3'd1;
        `MODE_X4:  shift_of = 3'd2;
        `MODE_X8:  shift_of = 3'd3;
        `MODE_X16: shift_of = 3'd4;
        `MODE_X32: shift_of = 3'd5;
        default:   shift_of = 3'd0;
      endcase
    end
  endfunction

  function is_par;
    input [3:0] mode;
    begin
      is_par = (mode == `MODE_X9) || (mode == `MODE_X18) ||
               (mode == `MODE_X36);
    end
  endfunction

  function [5:0] width_of;
    input [3:0] mode;
    begin
      case (mode)
        `MODE_X9:  width_of = 6'd9;
        `MODE_X18: width_of = 6'd18;
        `MODE_X36: width_of = 6'd36;
        default:   width_of = 6'd1 << shift_of(mode);
      endcase
    end
  endfunction

  // Byte masking only where lanes are whole bytes or nine-bit lanes
  function mask_ok;
    input [3:0] mode;
    begin
      mask_ok = (mode == `MODE_X16) || (mode == `MODE_X18) ||
                (mode == `MODE_X32) || (mode == `MODE_X36);
    end
  endfunction

  // Word index: logical address scaled into the 128-word array
  function [6:0] word_of;
    input [3:0]        mode;
    input [ADDR_W-1:0] addr;
    reg   [16:0]       bits;
    begin
      bits = {5'd0, addr} << shift_of(mode);
      case (mode)
        `MODE_X9:  word_of = addr[8:2];
        `MODE_X18: word_of = addr[7:1];
        `MODE_X36: word_of = addr[6:0];
        default:   word_of = bits[11:5];
      endcase
    end
  endfunction

  // Offset of the first accessed bit in the word's logical index space
  function [5:0] off_of;
    input [3:0]        mode;
    input [ADDR_W-1:0] addr;
    reg   [16:0]       bits;
    begin
      bits = {5'd0, addr} << shift_of(mode);
      case (mode)
        `MODE_X9:  off_of = {1'b0, addr[1:0], 3'd0} + {4'd0, addr[1:0]};
        `MODE_X18: off_of = addr[0] ? 6'd18 : 6'd0;
        `MODE_X36: off_of = 6'd0;
        default:   off_of = {1'b0, bits[4:0]};
      endcase
    end
  endfunction

  // Write mask and data over the 36 physical bits, packed {mask, data}
  function [71:0] wr_map;
    input [3:0]        mode;
    input [5:0]        off;
    input [DATA_W-1:0] din;
    input [BE_W-1:0]   be;
    integer p;
    integer li;
    integer j;
    integer lane;
    reg [35:0] m;
    reg [35:0] d;
    begin
      m = `ZERO36;
      d = `ZERO36;
      for (p = 0; p < `RB_WORD_W; p = p + 1) begin
        // Parity positions carry data only in 9/18/36 bit widths
        if (is_par(mode)) begin
          li = p;
        end else begin
          li = (p / `RB_LANE_W) * `RB_BYTE_W + (p % `RB_LANE_W);
        end
        j = li - off;
        lane = is_par(mode) ? j / `RB_LANE_W : j / `RB_BYTE_W;
        if ((is_par(mode) || (p % `RB_LANE_W) != `RB_PAR_POS) &&
            j >= 0 && j < width_of(mode) &&
            (!mask_ok(mode) || be[lane])) begin
          m[p] = 1'b1;
          d[p] = din[j];
        end
      end
      wr_map = {m, d};
    end
  endfunction

  // Gather the accessed bits of a physical word onto the data port
  function [DATA_W-1:0] rd_map;
    input [3:0]  mode;
    input [5:0]  off;
    input [35:0] word;
    integer p;
    integer li;
    integer j;
    reg [DATA_W-1:0] q;
    begin
      q = `ZERO36;
      for (p = 0; p < `RB_WORD_W; p = p + 1) begin
        li = is_par(mode) ? p :
             (p / `RB_LANE_W) * `RB_BYTE_W + (p % `RB_LANE_W);
        j = li - off;
        if ((is_par(mode) || (p % `RB_LANE_W) != `RB_PAR_POS) &&
            j >= 0 && j < width_of(mode)) begin
          q[j] = word[p];
        end
      end
      rd_map = q;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  reg  [`CTRL_W-1:0] ctrl_r;
  reg                collide_r;
  wire [3:0]         mode     = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire               outreg   = ctrl_r[`CTRL_OUTREG];
  wire               split    = ctrl_r[`CTRL_SPLIT];
  wire               old_data = ctrl_r[`CTRL_OLD_DATA];

  ////////////////////////////////////////////////////////////////////////
  // Input registers

  reg [ADDR_W-1:0] a_addr_r;
  reg [DATA_W-1:0] a_din_r;
  reg              a_wren_r;
  reg              a_rden_r;
  reg [BE_W-1:0]   a_be_r;
  reg [ADDR_W-1:0] b_addr_r;
  reg [DATA_W-1:0] b_din_r;
  reg              b_wren_r;
  reg              b_rden_r;
  reg [BE_W-1:0]   b_be_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_addr_r <= {ADDR_W{1'b0}};
      a_din_r  <= `ZERO36;
      a_wren_r <= 1'b0;
      a_rden_r <= 1'b1;
      a_be_r   <= `BE_ALL_ON;
      b_addr_r <= {ADDR_W{1'b0}};
      b_din_r  <= `ZERO36;
      b_wren_r <= 1'b0;
      b_rden_r <= 1'b1;
      b_be_r   <= `BE_ALL_ON;
    end else if (ce) begin
      if (clr_in) begin
        a_addr_r <= {ADDR_W{1'b0}};
        a_din_r  <= `ZERO36;
        a_wren_r <= 1'b0;
        a_rden_r <= 1'b1;
        a_be_r   <= `BE_ALL_ON;
        b_addr_r <= {ADDR_W{1'b0}};
        b_din_r  <= `ZERO36;
        b_wren_r <= 1'b0;
        b_rden_r <= 1'b1;
        b_be_r   <= `BE_ALL_ON;
      end else begin
        a_addr_r <= a_addr;
        a_din_r  <= a_din;
        a_wren_r <= a_wren;
        a_rden_r <= a_rden;
        a_be_r   <= a_byteen;
        b_addr_r <= b_addr;
        b_din_r  <= b_din;
        b_wren_r <= b_wren;
        b_rden_r <= b_rden;
        b_be_r   <= b_byteen;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address mapping and storage

  wire [6:0]  a_word = word_of(mode, a_addr_r);
  wire [6:0]  b_word = word_of(mode, b_addr_r);
  wire [5:0]  a_off  = off_of(mode, a_addr_r);
  wire [5:0]  b_off  = off_of(mode, b_addr_r);
  // In split mode A owns the lower half and B the upper half
  wire        a_half = split ? 1'b0 : a_word[6];
  wire        b_half = split ? 1'b1 : b_word[6];
  // Outside split mode the block is single-port, so B cannot write
  wire        b_we   = split & b_wren_r;
  wire [71:0] a_wmap = wr_map(mode, a_off, a_din_r, a_be_r);
  wire [71:0] b_wmap = wr_map(mode, b_off, b_din_r, b_be_r);

  wire [35:0] half_rd0 [0:1];
  wire [35:0] half_rd1 [0:1];

  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1) begin : g_half
      wire use_b = split && (h == 1);
      ram_half #(
        .ROWS   (`RB_HALF_WORDS),
        .ROW_AW (6),
        .WIDTH  (`RB_WORD_W)
      ) u_half (
        .clk    (clk),
        .ce     (ce),
        .we     (use_b ? b_we : (a_wren_r && a_half == h)),
        .waddr  (use_b ? b_word[5:0] : a_word[5:0]),
        .wmask  (use_b ? b_wmap[71:36] : a_wmap[71:36]),
        .wdata  (use_b ? b_wmap[35:0] : a_wmap[35:0]),
        .raddr0 (a_word[5:0]),
        .rdata0 (half_rd0[h]),
        .raddr1 (b_word[5:0]),
        .rdata1 (half_rd1[h])
      );
    end
  endgenerate

  wire [35:0] a_old = half_rd0[a_half];
  wire [35:0] b_old = half_rd1[b_half];
  // Mapped data is already zero outside the mask
  wire [35:0] a_new = (a_old & ~a_wmap[71:36]) | a_wmap[35:0];
  wire [35:0] b_new = (b_old & ~b_wmap[71:36]) | b_wmap[35:0];

  // B reads the word A writes in the same cycle (shared mode only)
  wire        collide = !split && a_wren_r && b_rden_r && a_word == b_word;

  ////////////////////////////////////////////////////////////////////////
  // Read paths: flow-through stage, then optional output register

  reg  [DATA_W-1:0] a_byp_r;
  reg  [DATA_W-1:0] b_byp_r;
  reg  [DATA_W-1:0] a_byp_nxt;
  reg  [DATA_W-1:0] b_byp_nxt;

  always @* begin
    a_byp_nxt = a_byp_r;
    if (a_wren_r) begin
      a_byp_nxt = rd_map(mode, a_off, a_new);
    end else if (a_rden_r) begin
      a_byp_nxt = rd_map(mode, a_off, a_old);
    end
    b_byp_nxt = b_byp_r;
    if (b_we) begin
      b_byp_nxt = rd_map(mode, b_off, b_new);
    end else if (b_rden_r) begin
      if (collide && !old_data) begin
        b_byp_nxt = `RDW_UNKNOWN;
      end else begin
        b_byp_nxt = rd_map(mode, b_off, b_old);
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_byp_r <= `ZERO36;
      b_byp_r <= `ZERO36;
      a_dout  <= `ZERO36;
      b_dout  <= `ZERO36;
    end else if (ce) begin
      if (clr_out) begin
        a_byp_r <= `ZERO36;
        b_byp_r <= `ZERO36;
        a_dout  <= `ZERO36;
        b_dout  <= `ZERO36;
      end else begin
        a_byp_r <= a_byp_nxt;
        b_byp_r <= b_byp_nxt;
        // Registered mode takes last cycle's value: one extra clock
        a_dout  <= outreg ? a_byp_r : a_byp_nxt;
        b_dout  <= outreg ? b_byp_r : b_byp_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: single-cycle ack, unmapped reads return zero

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_ctl = wb_req && wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0];
  wire wr_sts = wb_req && wb_we_i && wb_adr_i == `REG_STATUS && wb_sel_i[0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= `CTRL_RESET;
      collide_r <= 1'b0;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (wr_ctl) begin
        ctrl_r <= wb_dat_i[`CTRL_W-1:0];
      end
      // A new collision wins over a write-one clear in the same cycle
      if (collide) begin
        collide_r <= 1'b1;
      end else if (wr_sts && wb_dat_i[`STAT_COLLIDE]) begin
        collide_r <= 1'b0;
      end
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `REG_CTRL) begin
          wb_dat_o <= {{(32-`CTRL_W){1'b0}}, ctrl_r};
        end else if (wb_adr_i == `REG_STATUS) begin
          wb_dat_o <= {30'd0, collide_r, mask_ok(mode)};
        end
      end
    end
  end

endmodule
